// File: design/can_rx_filter_defs.vh
// Constants for the receive rule table and receive buffer block.
// Included by the block's design file; definitions only.
`ifndef CAN_RX_FILTER_DEFS_VH
`define CAN_RX_FILTER_DEFS_VH
// Register byte offsets on APB
`define OFS_GLOBAL_MODE 8'h00
`define OFS_GLOBAL_CONFIG_LOW 8'h04
`define OFS_RULE_COUNT_CONFIG 8'h08
`define OFS_RULE_TABLE_ACCESS_CTRL 8'h0c
`define OFS_RAM_WINDOW_CTRL 8'h10
`define OFS_RXBUF_COUNT_CONFIG 8'h14
`define OFS_RXBUF_IRQ_ENABLE 8'h18
`define OFS_RXFIFO0_CONFIG 8'h1c
`define OFS_RXFIFO1_CONFIG 8'h20
`define OFS_CFIFO_CONFIG 8'h24
`define OFS_ALLOC_STATUS 8'h28
`define OFS_FIFO_FILL 8'h2c
`define OFS_RULE_BASE 8'h40
`define RULE_WORDS 4
// Field positions
`define MODE_GLOBAL_RESET 0
`define MODE_CH_RESET 1
`define MODE_CH_HALT 2
`define MODE_MIRROR 3
`define CFG_DLC_CHECK 0
`define FIFO_IRQ_MODE 3
`define FIFO_IRQ_EN 4
`define CFIFO_RX_MODE 4
// Sizes
`define MAX_RULES 16
`define MAX_SLOTS 16
`define RAM_BYTES 1216
`define SLOT_BYTES 76
// Reset values
`define RST_MODE 4'h1
`endif

// File: design/can_rx_filter.v
// Receive rule table, acceptance filter and receive buffer allocator.
// Assumes an APB master on clock_i and a protocol engine that presents
// each received frame as a one-cycle frame_valid_i pulse on the same clock.
//
// Contract
// - At most sixteen receive rules
// - Rule writes need table write enable
// - Rule write: enable, page zero, channel reset/halt
// - Rule DLC compare only when check enabled
// - At most two FIFO targets per rule
// - Buffers plus FIFO depths total sixteen
// - 1216 RAM bytes, payload never limits
// - RAM allocated buffers, FIFOs, common, transmit
// - Receive buffer count zero to sixteen
// - Buffer payload size eight codes
// - Per receive buffer interrupt enable
// - Two FIFOs, depth 0,4,8,16
// - FIFO payload size eight codes
// - Threshold mode interrupt at fill level
// - Every-message mode interrupt per reception
// - First matching rule wins, else dropped
// - Compare only unmasked bits
// - Source select picks own or other frames
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "can_rx_filter_defs.vh"
module can_rx_filter #(
   parameter NRULES = `MAX_RULES
) (
   input wire clock_i,
   input wire rstn_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   input wire frame_valid_i,
   input wire frame_own_i,
   input wire frame_ide_i,
   input wire frame_rtr_i,
   input wire [28:0] frame_id_i,
   input wire [3:0] frame_dlc_i,
   input wire [1:0] fifo_pop_i,
   output reg stored_o,
   output reg [15:0] stored_label_o,
   output reg [15:0] rxbuf_irq_o,
   output reg [1:0] rxfifo_irq_o,
   output reg cfifo_store_o
);

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   reg [3:0] mode_ff;
   reg dlc_check_enable_ff;
   reg [4:0] rule_count_field_ff;
   reg rule_table_write_enable_ff;
   reg [1:0] ram_page_select_ff;
   reg [4:0] rxbuf_count_field_ff;
   reg [2:0] rxbuf_payload_ff;
   reg [15:0] rxbuf_irq_en_ff;
   reg [4:0] rxfifo_cfg_ff [0:1];
   reg [2:0] rxfifo_irq_threshold_ff [0:1];
   reg [2:0] rxfifo_payload_ff [0:1];
   reg [4:0] cfifo_cfg_ff;
   reg [4:0] fifo_fill_ff [0:1];
   // Rule table: id word, mask word, pointer word
   reg [31:0] rule_identifier_ff [0:NRULES-1];
   reg [31:0] rule_mask_ff [0:NRULES-1];
   reg [31:0] rule_pointer0_low_ff [0:NRULES-1];
   integer i;

   wire wr = psel_i & penable_i & pwrite_i;
   wire global_reset = mode_ff[`MODE_GLOBAL_RESET];
   wire rule_in_range = (paddr_i >= `OFS_RULE_BASE) &&
      (paddr_i < (`OFS_RULE_BASE + NRULES * 16));
   wire [3:0] rule_idx = paddr_i[7:4] - 4'h4;
   // Table protection: all three conditions at once
   wire rule_wr_ok = rule_table_write_enable_ff && (ram_page_select_ff == 2'h0) &&
      (mode_ff[`MODE_CH_RESET] | mode_ff[`MODE_CH_HALT]);

   assign pready_o = 1'b1;
   assign pslverr_o = 1'b0;

   // Depth code to slot count; codes above 3 read as zero slots
   function [4:0] depth_slots;
      input [2:0] code;
      begin
         case (code)
            3'h1: depth_slots = 5'h04;
            3'h2: depth_slots = 5'h08;
            3'h3: depth_slots = 5'h10;
            default: depth_slots = 5'h00;
         endcase
      end
   endfunction

   // Threshold code to message count: (code+1)/8 of depth
   function [4:0] threshold_level;
      input [2:0] code;
      input [4:0] depth;
      reg [8:0] prod;
      begin
         prod = ({6'h00, code} + 9'h001) * {4'h0, depth};
         threshold_level = prod[7:3];
      end
   endfunction

   // ----------------------------------------------------------------
   // Allocation: contiguous slot bases, total check
   // ----------------------------------------------------------------
   wire [4:0] f0_slots = depth_slots(rxfifo_cfg_ff[0][2:0]);
   wire [4:0] f1_slots = depth_slots(rxfifo_cfg_ff[1][2:0]);
   wire [4:0] cf_slots = depth_slots(cfifo_cfg_ff[2:0]);
   // Bases in slot units; transmit buffers start after the common FIFO
   wire [6:0] f0_base = {2'h0, rxbuf_count_field_ff};
   wire [6:0] f1_base = f0_base + {2'h0, f0_slots};
   wire [6:0] cf_base = f1_base + {2'h0, f1_slots};
   wire [6:0] tx_base = cf_base + {2'h0, cf_slots};
   // Every slot is sized for 76 bytes, so only the count can overflow
   wire alloc_err = tx_base > `MAX_SLOTS;

   // ----------------------------------------------------------------
   // APB writes
   // ----------------------------------------------------------------
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_ff <= `RST_MODE;
         dlc_check_enable_ff <= 1'b0;
         rule_count_field_ff <= 5'h00;
         rule_table_write_enable_ff <= 1'b0;
         ram_page_select_ff <= 2'h0;
         rxbuf_count_field_ff <= 5'h00;
         rxbuf_payload_ff <= 3'h0;
         rxbuf_irq_en_ff <= 16'h0000;
         cfifo_cfg_ff <= 5'h00;
         for (i = 0; i < 2; i = i + 1) begin
            rxfifo_cfg_ff[i] <= 5'h00;
            rxfifo_irq_threshold_ff[i] <= 3'h0;
            rxfifo_payload_ff[i] <= 3'h0;
         end
         for (i = 0; i < NRULES; i = i + 1) begin
            rule_identifier_ff[i] <= 32'h00000000;
            rule_mask_ff[i] <= 32'h00000000;
            rule_pointer0_low_ff[i] <= 32'h00000000;
         end
      end else if (wr) begin
         case (paddr_i)
            `OFS_GLOBAL_MODE: mode_ff <= pwdata_i[3:0];
            `OFS_GLOBAL_CONFIG_LOW: if (global_reset) begin
               dlc_check_enable_ff <= pwdata_i[`CFG_DLC_CHECK];
            end
            `OFS_RULE_COUNT_CONFIG: if (global_reset) begin
               // Counts above the table size clamp to the table size
               rule_count_field_ff <= (pwdata_i[4:0] > NRULES) ? NRULES[4:0] : pwdata_i[4:0];
            end
            `OFS_RULE_TABLE_ACCESS_CTRL: rule_table_write_enable_ff <= pwdata_i[0];
            `OFS_RAM_WINDOW_CTRL: ram_page_select_ff <= pwdata_i[1:0];
            `OFS_RXBUF_COUNT_CONFIG: if (global_reset) begin
               rxbuf_count_field_ff <= (pwdata_i[4:0] > 5'h10) ? 5'h10 : pwdata_i[4:0];
               rxbuf_payload_ff <= pwdata_i[10:8];
            end
            `OFS_RXBUF_IRQ_ENABLE: rxbuf_irq_en_ff <= pwdata_i[15:0];
            `OFS_RXFIFO0_CONFIG, `OFS_RXFIFO1_CONFIG: if (global_reset) begin
               rxfifo_cfg_ff[paddr_i == `OFS_RXFIFO1_CONFIG] <= pwdata_i[4:0];
               rxfifo_irq_threshold_ff[paddr_i == `OFS_RXFIFO1_CONFIG] <= pwdata_i[10:8];
               rxfifo_payload_ff[paddr_i == `OFS_RXFIFO1_CONFIG] <= pwdata_i[14:12];
            end
            `OFS_CFIFO_CONFIG: if (global_reset) begin
               cfifo_cfg_ff <= pwdata_i[4:0];
            end
            default: if (rule_in_range && rule_wr_ok) begin
               case (paddr_i[3:2])
                  2'h0: rule_identifier_ff[rule_idx] <= pwdata_i;
                  2'h1: rule_mask_ff[rule_idx] <= pwdata_i;
                  2'h2: rule_pointer0_low_ff[rule_idx] <= pwdata_i;
                  default: ;
               endcase
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // APB reads, unmapped addresses read zero
   // ----------------------------------------------------------------
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h00000000;
      case (paddr_i)
         `OFS_GLOBAL_MODE: rd_mux = {28'h0, mode_ff};
         `OFS_GLOBAL_CONFIG_LOW: rd_mux = {31'h0, dlc_check_enable_ff};
         `OFS_RULE_COUNT_CONFIG: rd_mux = {27'h0, rule_count_field_ff};
         `OFS_RULE_TABLE_ACCESS_CTRL: rd_mux = {31'h0, rule_table_write_enable_ff};
         `OFS_RAM_WINDOW_CTRL: rd_mux = {30'h0, ram_page_select_ff};
         `OFS_RXBUF_COUNT_CONFIG: rd_mux = {21'h0, rxbuf_payload_ff, 3'h0, rxbuf_count_field_ff};
         `OFS_RXBUF_IRQ_ENABLE: rd_mux = {16'h0, rxbuf_irq_en_ff};
         `OFS_RXFIFO0_CONFIG: rd_mux = {17'h0, rxfifo_payload_ff[0], 1'b0,
            rxfifo_irq_threshold_ff[0], 3'h0, rxfifo_cfg_ff[0]};
         `OFS_RXFIFO1_CONFIG: rd_mux = {17'h0, rxfifo_payload_ff[1], 1'b0,
            rxfifo_irq_threshold_ff[1], 3'h0, rxfifo_cfg_ff[1]};
         `OFS_CFIFO_CONFIG: rd_mux = {27'h0, cfifo_cfg_ff};
         `OFS_ALLOC_STATUS: rd_mux = {1'b0, tx_base, 1'b0, cf_base, 1'b0, f1_base, 7'h00, alloc_err};
         `OFS_FIFO_FILL: rd_mux = {19'h0, fifo_fill_ff[1], 3'h0, fifo_fill_ff[0]};
         default: if (rule_in_range) begin
            case (paddr_i[3:2])
               2'h0: rd_mux = rule_identifier_ff[rule_idx];
               2'h1: rd_mux = rule_mask_ff[rule_idx];
               2'h2: rd_mux = rule_pointer0_low_ff[rule_idx];
               default: rd_mux = 32'h00000000;
            endcase
         end
      endcase
   end

   // Read data captured in the setup cycle, so the access cycle sees a flop
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prdata_o <= 32'h00000000;
      end else if (psel_i && !penable_i) begin
         prdata_o <= rd_mux;
      end
   end

   // ----------------------------------------------------------------
   // Acceptance filter
   // id word: [28:0] id, [29] source, [30] rtr, [31] ide; mask same layout
   // pointer: [3:0] dlc, [4] rxbuf enable, [8:5] rxbuf index,
   //          [9] fifo0, [10] fifo1, [11] common fifo, [31:16] label
   // ----------------------------------------------------------------
   reg hit;
   reg [3:0] hit_idx;
   reg [31:0] cmp;
   reg [31:0] ptr;
   reg src_ok;
   reg dlc_ok;
   integer r;
   always @* begin
      hit = 1'b0;
      hit_idx = 4'h0;
      cmp = 32'h00000000;
      src_ok = 1'b0;
      dlc_ok = 1'b0;
      // Lowest numbered rule wins; loop runs backwards to get that
      for (r = NRULES - 1; r >= 0; r = r - 1) begin
         cmp = {frame_ide_i, frame_rtr_i, 1'b0, frame_id_i} ^ rule_identifier_ff[r];
         src_ok = rule_identifier_ff[r][29] ? (frame_own_i & mode_ff[`MODE_MIRROR]) : ~frame_own_i;
         dlc_ok = !dlc_check_enable_ff || (rule_pointer0_low_ff[r][3:0] == 4'h0) ||
            (frame_dlc_i >= rule_pointer0_low_ff[r][3:0]);
         if ((r < rule_count_field_ff) && src_ok && dlc_ok &&
            (({cmp[31:30], cmp[28:0]} & {rule_mask_ff[r][31:30], rule_mask_ff[r][28:0]}) == 31'h0)) begin
            hit = 1'b1;
            hit_idx = r[3:0];
         end
      end
      ptr = rule_pointer0_low_ff[hit_idx];
   end

   // Targets; fifo 1 is dropped whenever fifo 0 is set, and the common FIFO whenever a receive buffer is set
   wire rxbuf_go = hit && ptr[4] && (ptr[8:5] < rxbuf_count_field_ff);
   wire f0_go = hit && ptr[9] && (f0_slots != 5'h00) && (fifo_fill_ff[0] < f0_slots);
   wire f1_go = hit && ptr[10] && !(ptr[4] && ptr[9]) && !ptr[9] &&
      (f1_slots != 5'h00) && (fifo_fill_ff[1] < f1_slots);
   wire cf_go = hit && ptr[11] && !ptr[4] && cfifo_cfg_ff[`CFIFO_RX_MODE] && (cf_slots != 5'h00);
   wire [1:0] f_go = {f1_go, f0_go};

   // ----------------------------------------------------------------
   // Fill levels and one-cycle event outputs
   // ----------------------------------------------------------------
   integer k;
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fifo_fill_ff[0] <= 5'h00;
         fifo_fill_ff[1] <= 5'h00;
         stored_o <= 1'b0;
         stored_label_o <= 16'h0000;
         rxbuf_irq_o <= 16'h0000;
         rxfifo_irq_o <= 2'h0;
         cfifo_store_o <= 1'b0;
      end else begin
         stored_o <= frame_valid_i && hit && !alloc_err;
         stored_label_o <= ptr[31:16];
         cfifo_store_o <= frame_valid_i && cf_go && !alloc_err;
         rxbuf_irq_o <= (frame_valid_i && rxbuf_go && !alloc_err) ?
            ((16'h0001 << ptr[8:5]) & rxbuf_irq_en_ff) : 16'h0000;
         for (k = 0; k < 2; k = k + 1) begin
            // A pop in the same cycle as a store keeps the level unless the fifo is empty
            if (frame_valid_i && f_go[k] && !alloc_err) begin
               if (!(fifo_pop_i[k] && fifo_fill_ff[k] != 5'h00)) begin
                  fifo_fill_ff[k] <= fifo_fill_ff[k] + 5'h01;
               end
               if (rxfifo_cfg_ff[k][`FIFO_IRQ_MODE]) begin
                  rxfifo_irq_o[k] <= rxfifo_cfg_ff[k][`FIFO_IRQ_EN];
               end else begin
                  // Fires once, on the store that reaches the level
                  rxfifo_irq_o[k] <= rxfifo_cfg_ff[k][`FIFO_IRQ_EN] && (fifo_fill_ff[k] + 5'h01 ==
                     threshold_level(rxfifo_irq_threshold_ff[k], f_slots(k)));
               end
            end else begin
               rxfifo_irq_o[k] <= 1'b0;
               if (fifo_pop_i[k] && fifo_fill_ff[k] != 5'h00) begin
                  fifo_fill_ff[k] <= fifo_fill_ff[k] - 5'h01;
               end
            end
         end
      end
   end

   // Slot count of receive FIFO k
   function [4:0] f_slots;
      input integer idx;
      begin
         f_slots = (idx == 0) ? f0_slots : f1_slots;
      end
   endfunction

endmodule
`default_nettype wire

// File: bench/can_rx_filter_props.sv
// Checker for the receive filter block's frame outputs and bus answer.
// Assumes it is bound to can_rx_filter; one clock, async active-low reset.
`timescale 1ns/10ps
`default_nettype none
module can_rx_filter_props (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic frame_valid_i,
   input wire logic stored_o,
   input wire logic [15:0] rxbuf_irq_o,
   input wire logic [1:0] rxfifo_irq_o,
   input wire logic cfifo_store_o
);
   // ----
   // Output relations
   // ----
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   // Every event is one cycle after a frame, never without one
   AST_QUIET_NO_FRAME: assert property (!frame_valid_i |=> !stored_o && !cfifo_store_o)
      else $error("store pulse without a frame");
   AST_STORE_CAUSE: assert property (stored_o |-> $past(frame_valid_i))
      else $error("store not caused by a frame");
   AST_BUF_IRQ_PULSE: assert property (!frame_valid_i |=> rxbuf_irq_o == 16'h0000)
      else $error("buffer interrupt without a frame");
   AST_BUF_IRQ_CAUSE: assert property (|rxbuf_irq_o |-> stored_o)
      else $error("buffer interrupt without a store");
   AST_BUF_ONE: assert property ($onehot0(rxbuf_irq_o))
      else $error("two receive buffers in one store");
   AST_FIFO_ONE: assert property (rxfifo_irq_o != 2'b11)
      else $error("both receive fifos in one store");
   AST_FIFO_IRQ_CAUSE: assert property (|rxfifo_irq_o |-> stored_o && $past(frame_valid_i))
      else $error("fifo interrupt without a store");
   AST_CFIFO_CAUSE: assert property (cfifo_store_o |-> stored_o)
      else $error("common store without a match");
   AST_BUS_ANSWER: assert property (pready_o && !pslverr_o)
      else $error("bus answer not ready or error");
endmodule
bind can_rx_filter can_rx_filter_props can_rx_filter_props_inst (
   .clock_i(clock_i),
   .rstn_i(rstn_i),
   .pready_o(pready_o),
   .pslverr_o(pslverr_o),
   .frame_valid_i(frame_valid_i),
   .stored_o(stored_o),
   .rxbuf_irq_o(rxbuf_irq_o),
   .rxfifo_irq_o(rxfifo_irq_o),
   .cfifo_store_o(cfifo_store_o)
);
`default_nettype wire

// File: bench/can_node_model.sv
// Stand-in for the other nodes on the bus, as seen through the protocol engine.
// Assumes the receive block samples the fields at the rising edge of clock_i.
`timescale 1ns/10ps
`default_nettype none
module can_node_model (
   input wire logic clock_i,
   output logic frame_valid_o,
   output logic frame_own_o,
   output logic frame_ide_o,
   output logic frame_rtr_o,
   output logic [28:0] frame_id_o,
   output logic [3:0] frame_dlc_o
);
   logic busy = 1'b0;
   // ----
   // Frame driver
   // ----
   initial begin
      frame_valid_o = 1'b0;
      {frame_own_o, frame_ide_o, frame_rtr_o, frame_id_o, frame_dlc_o} = '0;
   end
   // Fields other than ide wander between frames so a stale value never matches by luck
   always @(posedge clock_i) begin
      if (!busy) begin
         frame_id_o <= ~frame_id_o;
         frame_dlc_o <= ~frame_dlc_o;
         frame_rtr_o <= ~frame_rtr_o;
         frame_own_o <= ~frame_own_o;
      end
   end
   // One frame, valid for exactly one cycle
   task automatic send(input logic [28:0] id, input logic own, rtr, input logic [3:0] dlc);
      busy = 1'b1;
      @(posedge clock_i);
      frame_valid_o <= 1'b1;
      frame_own_o <= own;
      frame_ide_o <= 1'b0;
      frame_rtr_o <= rtr;
      frame_id_o <= {18'h0, id[10:0]};
      frame_dlc_o <= dlc;
      @(posedge clock_i);
      frame_valid_o <= 1'b0;
      busy = 1'b0;
   endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the receive rule table and buffer allocator.
// Assumes the design header is on the include path; one 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "can_rx_filter_defs.vh"
module tb;
   typedef struct packed {logic [28:0] id; logic own, rtr; logic [3:0] dlc; logic st;
      logic [15:0] lab, bi; logic [1:0] fi; logic cf;} row_t;
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, rd;
   logic [1:0] fifo_pop_i = 2'b00;
   wire [31:0] prdata_o;
   wire pready_o, pslverr_o, frame_valid_i, frame_own_i, frame_ide_i, frame_rtr_i, stored_o, cfifo_store_o;
   wire [28:0] frame_id_i;
   wire [3:0] frame_dlc_i;
   wire [15:0] stored_label_o, rxbuf_irq_o;
   wire [1:0] rxfifo_irq_o;
   int miscompares = 0, checks_done = 0;
   // Rule words: rule 0 (ids 120-123, dlc 6, buffer 3 + fifo 1), rule 1 (id 130, fifo 0 + common)
   logic [31:0] rw [6] = '{32'h120, 32'hdffffffc, 32'h00100476, 32'h130, 32'hbfffffff, 32'h01300a00};
   // Frame in, then stored, label, buffer irq, fifo irq, common store
   row_t rows [7] = '{'{29'h123, 0, 0, 4'd6, 1, 16'h0010, 16'h0008, 2'b10, 0},
      '{29'h122, 0, 0, 4'd5, 0, 0, 0, 0, 0}, '{29'h124, 0, 0, 4'd8, 0, 0, 0, 0, 0},
      '{29'h130, 0, 1, 4'd0, 1, 16'h0130, 0, 2'b01, 1}, '{29'h130, 0, 0, 4'd0, 1, 16'h0130, 0, 2'b01, 1},
      '{29'h121, 1, 0, 4'd7, 0, 0, 0, 0, 0}, '{29'h121, 0, 0, 4'd7, 1, 16'h0010, 16'h0008, 2'b00, 0}};
   can_rx_filter can_rx_filter_inst (.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .frame_valid_i(frame_valid_i),
      .frame_own_i(frame_own_i), .frame_ide_i(frame_ide_i), .frame_rtr_i(frame_rtr_i),
      .frame_id_i(frame_id_i), .frame_dlc_i(frame_dlc_i), .fifo_pop_i(fifo_pop_i), .stored_o(stored_o),
      .stored_label_o(stored_label_o), .rxbuf_irq_o(rxbuf_irq_o), .rxfifo_irq_o(rxfifo_irq_o),
      .cfifo_store_o(cfifo_store_o));
   can_node_model can_node_model_inst (.clock_i(clock_i), .frame_valid_o(frame_valid_i),
      .frame_own_o(frame_own_i), .frame_ide_o(frame_ide_i), .frame_rtr_o(frame_rtr_i),
      .frame_id_o(frame_id_i), .frame_dlc_o(frame_dlc_i));
   // ----
   // Helpers
   // ----
   always #5 clock_i = ~clock_i;
   task automatic check(input string name, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready_o !== 1'b1 && n < 16);
      rd = prdata_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (n >= 16) begin
         miscompares++;
         tally_and_finish();
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
      apb(1'b0, a, 32'h0);
      check(name, rd, exp);
   endtask
   // ----
   // Sequence
   // ----
   initial begin
      repeat (6) @(posedge clock_i);
      check("outputs in reset", {stored_o, cfifo_store_o, rxfifo_irq_o, rxbuf_irq_o}, 32'h0);
      rstn_i <= 1'b1;
      rchk(`OFS_GLOBAL_MODE, 32'h1, "mode after reset");
      apb(1'b1, `OFS_RULE_COUNT_CONFIG, 32'h1f);
      rchk(`OFS_RULE_COUNT_CONFIG, 32'h10, "rule count clamp");
      apb(1'b1, `OFS_RXBUF_COUNT_CONFIG, 32'h11);
      rchk(`OFS_RXBUF_COUNT_CONFIG, 32'h10, "buffer count clamp");
      rchk(8'h3c, 32'h0, "unmapped");
      $display("test reset and clamps done");
      apb(1'b1, `OFS_RULE_COUNT_CONFIG, 32'h2);
      apb(1'b1, `OFS_RXBUF_COUNT_CONFIG, 32'h704);
      apb(1'b1, `OFS_RXBUF_IRQ_ENABLE, 32'h8);
      apb(1'b1, `OFS_RXFIFO0_CONFIG, 32'h19);
      apb(1'b1, `OFS_RXFIFO1_CONFIG, 32'h7111);
      apb(1'b1, `OFS_CFIFO_CONFIG, 32'h11);
      apb(1'b1, `OFS_GLOBAL_CONFIG_LOW, 32'h1);
      rchk(`OFS_RXFIFO1_CONFIG, 32'h7111, "fifo config");
      rchk(`OFS_ALLOC_STATUS, 32'h100c0800, "allocation");
      // Rule writes refused until enable, page zero and channel reset all hold
      apb(1'b1, `OFS_RULE_BASE, 32'h120);
      rchk(`OFS_RULE_BASE, 32'h0, "locked table");
      apb(1'b1, `OFS_RULE_TABLE_ACCESS_CTRL, 32'h1);
      apb(1'b1, `OFS_RULE_BASE, 32'h120);
      rchk(`OFS_RULE_BASE, 32'h0, "no channel reset");
      apb(1'b1, `OFS_GLOBAL_MODE, 32'h3);
      apb(1'b1, `OFS_RAM_WINDOW_CTRL, 32'h1);
      apb(1'b1, `OFS_RULE_BASE, 32'h120);
      rchk(`OFS_RULE_BASE, 32'h0, "wrong page");
      apb(1'b1, `OFS_RAM_WINDOW_CTRL, 32'h0);
      foreach (rw[k]) apb(1'b1, 8'(64 + 16 * (k / 3) + 4 * (k % 3)), rw[k]);
      // Channel halt opens the table as well; rule 2 lies beyond the count
      apb(1'b1, `OFS_GLOBAL_MODE, 32'h5);
      apb(1'b1, 8'h60, 32'h555);
      rchk(8'h60, 32'h555, "halt mode write");
      apb(1'b1, `OFS_RULE_TABLE_ACCESS_CTRL, 32'h0);
      apb(1'b1, `OFS_RULE_BASE, 32'h7ff);
      rchk(`OFS_RULE_BASE, 32'h120, "relocked table");
      rchk(8'h48, 32'h00100476, "rule pointer");
      apb(1'b1, `OFS_GLOBAL_MODE, 32'h8);
      apb(1'b1, `OFS_RXBUF_COUNT_CONFIG, 32'h2);
      rchk(`OFS_RXBUF_COUNT_CONFIG, 32'h704, "config outside reset");
      $display("test configuration done");
      foreach (rows[k]) begin
         can_node_model_inst.send(rows[k].id, rows[k].own, rows[k].rtr, rows[k].dlc);
         #1;
         check("stored", stored_o, rows[k].st);
         if (rows[k].st) check("label", stored_label_o, rows[k].lab);
         check("buffer irq", rxbuf_irq_o, rows[k].bi);
         check("fifo irq", rxfifo_irq_o, rows[k].fi);
         check("common store", cfifo_store_o, rows[k].cf);
      end
      $display("test frame table done");
      // Short length passes once the length check is off
      apb(1'b1, `OFS_GLOBAL_MODE, 32'h1);
      apb(1'b1, `OFS_GLOBAL_CONFIG_LOW, 32'h0);
      apb(1'b1, `OFS_GLOBAL_MODE, 32'h8);
      can_node_model_inst.send(29'h122, 1'b0, 1'b0, 4'd5);
      #1;
      check("unchecked length", {stored_o, stored_label_o}, 32'h10010);
      rchk(`OFS_FIFO_FILL, 32'h0302, "fill levels");
      @(posedge clock_i);
      fifo_pop_i <= 2'b01;
      @(posedge clock_i);
      fifo_pop_i <= 2'b00;
      rchk(`OFS_FIFO_FILL, 32'h0301, "fill after pop");
      $display("test length check and pop done");
      // Unused fifo gives its slots back; an overrun blocks every store
      apb(1'b1, `OFS_GLOBAL_MODE, 32'h1);
      apb(1'b1, `OFS_RXFIFO1_CONFIG, 32'h0);
      rchk(`OFS_ALLOC_STATUS, 32'h0c080800, "unused fifo");
      apb(1'b1, `OFS_RXBUF_COUNT_CONFIG, 32'h10);
      rchk(`OFS_ALLOC_STATUS, 32'h18141401, "overrun status");
      can_node_model_inst.send(29'h123, 1'b0, 1'b0, 4'd6);
      #1;
      check("overrun store", {stored_o, rxbuf_irq_o, rxfifo_irq_o}, 32'h0);
      $display("test allocation limits done");
      // Reset again in mid-run; configuration returns to its reset values
      @(posedge clock_i);
      rstn_i <= 1'b0;
      @(posedge clock_i);
      rstn_i <= 1'b1;
      rchk(`OFS_RXBUF_COUNT_CONFIG, 32'h0, "count after reset");
      rchk(`OFS_FIFO_FILL, 32'h0, "fill after reset");
      $display("test mid-run reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
